/* inc/fbc_map.svh */
// Opcodes, buffer geometry, address field positions and timing constants
`ifndef FBC_MAP_SVH
`define FBC_MAP_SVH

`define FBC_OP_RD1_FAST 8'hd4
`define FBC_OP_RD1_SLOW 8'hd1
`define FBC_OP_RD2_FAST 8'hd6
`define FBC_OP_RD2_SLOW 8'hd3
`define FBC_OP_WR1 8'h84
`define FBC_OP_WR2 8'h87
`define FBC_OP_PGE1 8'h83
`define FBC_OP_PGE2 8'h86
`define FBC_OP_PG1 8'h88
`define FBC_OP_PG2 8'h89
`define FBC_OP_WPE1 8'h82
`define FBC_OP_WPE2 8'h85

`define FBC_BUF_LAST_528 10'h20f
`define FBC_BUF_LAST_512 10'h1ff
`define FBC_PAGE_LSB_528 10
`define FBC_PAGE_LSB_512 9
`define FBC_ADDR_BYTES 3
`define FBC_DUMMY_BYTE 8'h00

`define FBC_CLK_NS 25
`define FBC_T_EP_NS 40000
`define FBC_T_P_NS 20000
`define FBC_SCK_HALF 2

`endif

/* inc/fbc_pkg.sv */
// Shared types and opcode decoding for both link ends
`include "fbc_map.svh"

package fbc_pkg;

    typedef enum logic [2:0] {
        OP_NONE, OP_RD_FAST, OP_RD_SLOW, OP_WR, OP_PGM_ERASE, OP_PGM, OP_WR_PGM
    } fbc_op_e;

    typedef enum logic [2:0] {
        DS_OPC, DS_ADDR, DS_DUMMY, DS_RD, DS_WR, DS_HOLD, DS_IGN
    } fbc_dst_e;

    typedef enum logic [2:0] {
        HS_IDLE, HS_LOAD, HS_SHIFT, HS_END, HS_GAP
    } fbc_hst_e;

    function automatic fbc_op_e fbc_decode(input logic [7:0] opc);
        case (opc)
            `FBC_OP_RD1_FAST, `FBC_OP_RD2_FAST: fbc_decode = OP_RD_FAST;
            `FBC_OP_RD1_SLOW, `FBC_OP_RD2_SLOW: fbc_decode = OP_RD_SLOW;
            `FBC_OP_WR1, `FBC_OP_WR2: fbc_decode = OP_WR;
            `FBC_OP_PGE1, `FBC_OP_PGE2: fbc_decode = OP_PGM_ERASE;
            `FBC_OP_PG1, `FBC_OP_PG2: fbc_decode = OP_PGM;
            `FBC_OP_WPE1, `FBC_OP_WPE2: fbc_decode = OP_WR_PGM;
            default: fbc_decode = OP_NONE;
        endcase
    endfunction

    // High when the opcode addresses the second buffer
    function automatic logic fbc_second_buf(input logic [7:0] opc);
        case (opc)
            `FBC_OP_RD2_FAST, `FBC_OP_RD2_SLOW, `FBC_OP_WR2,
            `FBC_OP_PGE2, `FBC_OP_PG2, `FBC_OP_WPE2: fbc_second_buf = 1'b1;
            default: fbc_second_buf = 1'b0;
        endcase
    endfunction

endpackage

/* inc/fbc_if.sv */
// Serial link between the flash buffer engine and its host
`timescale 1ns/1ps
`default_nettype none

interface fbc_if;
    logic cs_b;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic so_level;

    // Released serial output floats high
    assign so_level = miso_oe ? miso : 1'b1;

    modport dev(input cs_b, input sck, input mosi, output miso, output miso_oe);
    modport host(output cs_b, output sck, output mosi, input so_level);
endinterface

`default_nettype wire

/* rtl/fbc_dev.sv */
// Device end: buffer read, write and buffer-to-page program sequencing
`timescale 1ns/1ps
`default_nettype none
`include "fbc_map.svh"

module fbc_dev
    import fbc_pkg::*;
#(
    parameter int EP_CYCLES = `FBC_T_EP_NS / `FBC_CLK_NS,
    parameter int P_CYCLES = `FBC_T_P_NS / `FBC_CLK_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    fbc_if.dev lnk,
    // Configuration
    input wire logic page_512,
    // Array side
    input wire logic verify_fail,
    output logic array_start,
    output logic array_erase,
    output logic array_buf,
    output logic [11:0] array_page,
    // Status
    output logic busy,
    output logic erase_program_error_flag
);

    typedef struct packed {
        fbc_dst_e st;
        logic sck_q;
        logic cs_q;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [1:0] nadr;
        fbc_op_e op;
        logic bsel;
        logic [15:0] addr;
        logic [9:0] ptr;
        logic [11:0] page;
        logic [7:0] txb;
        logic reload;
        logic miso;
        logic oe;
        logic busy;
        logic err;
        logic fail_seen;
        logic [15:0] tmr;
        logic start;
        logic erase;
        logic pbuf;
        logic [11:0] ppage;
    } fbc_dev_s;

    fbc_dev_s s;
    fbc_dev_s next_s;
    logic [7:0] buf_mem [2][528];
    logic we;
    logic wsel;
    logic [9:0] wptr;
    logic [7:0] wdat;

    always_comb begin
        logic rise;
        logic fall;
        logic [7:0] b;
        logic [9:0] last;
        logic [9:0] nxt_ptr;
        logic [23:0] a;
        next_s = s;
        we = 1'b0;
        wsel = s.bsel;
        wptr = s.ptr;
        wdat = 8'h00;
        rise = lnk.sck & ~s.sck_q & ~lnk.cs_b;
        fall = ~lnk.sck & s.sck_q & ~lnk.cs_b;
        b = {s.sh[6:0], lnk.mosi};
        a = {s.addr, b};
        last = page_512 ? `FBC_BUF_LAST_512 : `FBC_BUF_LAST_528;
        nxt_ptr = (s.ptr == last) ? 10'h000 : s.ptr + 10'h001;
        next_s.sck_q = lnk.sck;
        next_s.cs_q = lnk.cs_b;
        next_s.start = 1'b0;

        // Self-timed operation countdown
        if (s.busy) begin
            next_s.fail_seen = s.fail_seen | verify_fail;
            if (s.tmr == 16'h0001) begin
                next_s.busy = 1'b0;
                next_s.err = s.fail_seen | verify_fail;
            end else begin
                next_s.tmr = s.tmr - 16'h0001;
            end
        end

        if (lnk.cs_b) begin
            if (!s.cs_q && !s.busy &&
                (s.st == DS_HOLD || (s.st == DS_WR && s.op == OP_WR_PGM))) begin
                next_s.busy = 1'b1;
                next_s.start = 1'b1;
                next_s.erase = (s.op != OP_PGM);
                next_s.tmr = (s.op == OP_PGM) ? 16'(P_CYCLES) : 16'(EP_CYCLES);
                next_s.err = 1'b0;
                next_s.fail_seen = 1'b0;
                next_s.pbuf = s.bsel;
                next_s.ppage = s.page;
            end
            // Any state before the address is complete simply returns here
            next_s.st = DS_OPC;
            next_s.bitc = 3'h0;
            next_s.nadr = 2'h0;
            next_s.oe = 1'b0;
            next_s.reload = 1'b0;
        end else if (rise) begin
            next_s.sh = b;
            next_s.bitc = s.bitc + 3'h1;
            if (s.bitc == 3'h7) begin
                case (s.st)
                    DS_OPC: begin
                        next_s.op = fbc_decode(b);
                        next_s.bsel = fbc_second_buf(b);
                        next_s.st = (fbc_decode(b) == OP_NONE) ? DS_IGN : DS_ADDR;
                        next_s.nadr = 2'h0;
                    end
                    DS_ADDR: begin
                        next_s.addr = a[15:0];
                        next_s.nadr = s.nadr + 2'h1;
                        if (s.nadr == 2'(`FBC_ADDR_BYTES - 1)) begin
                            if (page_512) begin
                                next_s.ptr = {1'b0, a[8:0]};
                                next_s.page = a[`FBC_PAGE_LSB_512 +: 12];
                            end else begin
                                next_s.ptr = a[9:0];
                                next_s.page = a[`FBC_PAGE_LSB_528 +: 12];
                            end
                            case (s.op)
                                OP_RD_FAST: next_s.st = DS_DUMMY;
                                OP_RD_SLOW: begin
                                    next_s.st = DS_RD;
                                    next_s.reload = 1'b1;
                                end
                                OP_WR, OP_WR_PGM: next_s.st = DS_WR;
                                OP_PGM_ERASE, OP_PGM: next_s.st = DS_HOLD;
                                default: next_s.st = DS_IGN;
                            endcase
                        end
                    end
                    DS_DUMMY: begin
                        next_s.st = DS_RD;
                        next_s.reload = 1'b1;
                    end
                    DS_RD: next_s.reload = 1'b1;
                    DS_WR: begin
                        we = 1'b1;
                        wdat = b;
                        next_s.ptr = nxt_ptr;
                    end
                    default: next_s.st = s.st;
                endcase
            end
        end else if (fall && s.st == DS_RD) begin
            if (s.reload) begin
                next_s.txb = buf_mem[s.bsel][s.ptr];
                next_s.miso = buf_mem[s.bsel][s.ptr][7];
                next_s.oe = 1'b1;
                next_s.ptr = nxt_ptr;
                next_s.reload = 1'b0;
            end else begin
                next_s.txb = {s.txb[6:0], 1'b0};
                next_s.miso = s.txb[6];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= DS_OPC;
            s.op <= OP_NONE;
            s.cs_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            buf_mem[wsel][wptr] <= wdat;
        end
    end

    assign lnk.miso = s.miso;
    assign lnk.miso_oe = s.oe;
    assign array_start = s.start;
    assign array_erase = s.erase;
    assign array_buf = s.pbuf;
    assign array_page = s.ppage;
    assign busy = s.busy;
    assign erase_program_error_flag = s.err;

endmodule

`default_nettype wire

/* rtl/fbc_host.sv */
// Host end: frames commands on the serial link, with a write data FIFO
`timescale 1ns/1ps
`default_nettype none
`include "fbc_map.svh"

module fbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fbc_fifo_s;

    fbc_fifo_s s;
    fbc_fifo_s next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;

    assign out_valid = (s.wp != s.rp);
    assign in_ready = (s.wp != {~s.rp[AW], s.rp[AW-1:0]});
    assign push = in_valid & in_ready;
    assign out_data = mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = s.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_s.rp = s.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

module fbc_host
    import fbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    fbc_if.host lnk,
    // Command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [23:0] cmd_addr,
    input wire logic [9:0] cmd_len,
    // Write data
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    // Read data
    output logic rd_valid,
    output logic [7:0] rd_data
);

    typedef struct packed {
        fbc_hst_e st;
        logic [1:0] div;
        logic sck;
        logic cs_b;
        logic mosi;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] bitc;
        logic [2:0] idx;
        logic [2:0] nhdr;
        logic [9:0] left;
        logic [7:0] opc;
        logic [23:0] addr;
        logic is_read;
        logic rdv;
        logic [7:0] rdd;
    } fbc_host_s;

    fbc_host_s s;
    fbc_host_s next_s;
    logic f_valid;
    logic f_pop;
    logic [7:0] f_data;

    fbc_fifo #(.WIDTH(8), .DEPTH(16)) u_wr_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(wr_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    always_comb begin
        logic tick;
        logic [7:0] hdr;
        fbc_op_e op;
        hdr = 8'h00;
        next_s = s;
        f_pop = 1'b0;
        tick = (s.div == 2'(`FBC_SCK_HALF - 1));
        next_s.div = tick ? 2'h0 : s.div + 2'h1;
        next_s.rdv = 1'b0;
        op = fbc_decode(cmd_opcode);
        case (s.idx)
            3'h0: hdr = s.opc;
            3'h1: hdr = s.addr[23:16];
            3'h2: hdr = s.addr[15:8];
            3'h3: hdr = s.addr[7:0];
            default: hdr = `FBC_DUMMY_BYTE;
        endcase
        case (s.st)
            HS_IDLE: begin
                if (cmd_valid) begin
                    next_s.cs_b = 1'b0;
                    next_s.opc = cmd_opcode;
                    next_s.addr = cmd_addr;
                    next_s.left = cmd_len;
                    next_s.idx = 3'h0;
                    next_s.is_read = (op == OP_RD_FAST) || (op == OP_RD_SLOW);
                    next_s.nhdr = (op == OP_RD_FAST) ? 3'h5 : 3'h4;
                    next_s.st = HS_LOAD;
                end
            end
            HS_LOAD: begin
                if (tick) begin
                    if (s.idx < s.nhdr) begin
                        next_s.tx = hdr;
                        next_s.mosi = hdr[7];
                        next_s.bitc = 3'h0;
                        next_s.st = HS_SHIFT;
                    end else if (s.left == 10'h000) begin
                        next_s.st = HS_END;
                    end else if (s.is_read) begin
                        next_s.tx = `FBC_DUMMY_BYTE;
                        next_s.mosi = 1'b0;
                        next_s.bitc = 3'h0;
                        next_s.st = HS_SHIFT;
                    end else if (f_valid) begin
                        f_pop = 1'b1;
                        next_s.tx = f_data;
                        next_s.mosi = f_data[7];
                        next_s.bitc = 3'h0;
                        next_s.st = HS_SHIFT;
                    end
                end
            end
            HS_SHIFT: begin
                if (tick) begin
                    if (!s.sck) begin
                        next_s.sck = 1'b1;
                        next_s.rx = {s.rx[6:0], lnk.so_level};
                    end else begin
                        next_s.sck = 1'b0;
                        next_s.bitc = s.bitc + 3'h1;
                        if (s.bitc == 3'h7) begin
                            if (s.idx < s.nhdr) begin
                                next_s.idx = s.idx + 3'h1;
                            end else begin
                                next_s.left = s.left - 10'h001;
                                next_s.rdv = s.is_read;
                                next_s.rdd = s.rx;
                            end
                            next_s.st = HS_LOAD;
                        end else begin
                            next_s.tx = {s.tx[6:0], 1'b0};
                            next_s.mosi = s.tx[6];
                        end
                    end
                end
            end
            HS_END: begin
                if (tick) begin
                    next_s.cs_b = 1'b1;
                    next_s.st = HS_GAP;
                end
            end
            HS_GAP: begin
                if (tick) begin
                    next_s.st = HS_IDLE;
                end
            end
            default: next_s.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= HS_IDLE;
            s.cs_b <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready = (s.st == HS_IDLE);
    assign lnk.cs_b = s.cs_b;
    assign lnk.sck = s.sck;
    assign lnk.mosi = s.mosi;
    assign rd_valid = s.rdv;
    assign rd_data = s.rdd;

endmodule

`default_nettype wire

/* test/fbc_check_sva.sv */
// Checker for the serial link and self-timed status of the buffer engine
`timescale 1ns/1ps
`default_nettype none

module fbc_check #(
    parameter int EP_CYCLES = 8,
    parameter int P_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link
    input wire logic cs_b,
    input wire logic sck,
    input wire logic miso_oe,
    // Device status
    input wire logic busy,
    input wire logic array_start,
    input wire logic array_erase,
    input wire logic erase_program_error_flag
);
    typedef struct packed {
        logic [15:0] run;
    } fbc_chk_s;

    fbc_chk_s st;
    fbc_chk_s next_st;

    // Length of the current busy stretch
    always_comb begin
        next_st = st;
        next_st.run = busy ? st.run + 16'h0001 : 16'h0000;
        if (!rst_b) begin
            next_st.run = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_oe_release;
        $past(cs_b, 2) && $past(cs_b) && cs_b |-> !miso_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("serial output driven while deselected");

    property p_sck_idle;
        cs_b |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock high outside a frame");

    property p_start_desel;
        array_start |-> $past(cs_b);
    endproperty
    a_start_desel: assert property (p_start_desel)
        else $error("operation started without deselect");

    property p_start_idle;
        array_start |-> !$past(busy);
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("operation started while busy");

    property p_start_busy;
        array_start |-> busy ##1 (busy && !array_start);
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("busy not held after start");

    property p_busy_rise;
        $rose(busy) |-> array_start;
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy rose without a start");

    property p_busy_len;
        $fell(busy) |-> st.run == 16'(array_erase ? EP_CYCLES : P_CYCLES);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong for operation kind");

    property p_err_at_end;
        $rose(erase_program_error_flag) |-> $fell(busy);
    endproperty
    a_err_at_end: assert property (p_err_at_end)
        else $error("error flag set outside completion");

    property p_err_clr;
        busy && $past(busy) |-> !erase_program_error_flag;
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("error flag not cleared by new operation");

    c_erase_op: cover property ($fell(busy) && array_erase);
    c_plain_op: cover property ($fell(busy) && !array_erase);
    c_error: cover property ($rose(erase_program_error_flag));
    c_read: cover property ($rose(miso_oe));
endmodule

`default_nettype wire

/* test/test_flash_buffer_command_engine.sv */
// Bench joining host and device ends for buffer and program commands
`timescale 1ns/1ps
`default_nettype none

module test_flash_buffer_command_engine;
    localparam int EPC = 8;
    localparam int PC = 4;

    logic clk, rst_b, page_512, verify_fail, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid;
    logic busy, err, array_start, array_erase, array_buf, s_erase, s_buf;
    logic [7:0] cmd_opcode, wr_data, rd_data;
    logic [23:0] cmd_addr;
    logic [9:0] cmd_len;
    logic [11:0] array_page, s_page;
    logic [7:0] rx_q[$];
    int bad_count, n_checks, n_start, run, last_len;

    fbc_if lnk();

    fbc_dev #(.EP_CYCLES(EPC), .P_CYCLES(PC)) i_fbc_dev (
        .clk(clk), .rst_b(rst_b), .lnk(lnk.dev), .page_512(page_512),
        .verify_fail(verify_fail), .array_start(array_start), .array_erase(array_erase),
        .array_buf(array_buf), .array_page(array_page), .busy(busy),
        .erase_program_error_flag(err));

    fbc_host i_fbc_host (
        .clk(clk), .rst_b(rst_b), .lnk(lnk.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data));

    fbc_check #(.EP_CYCLES(EPC), .P_CYCLES(PC)) i_fbc_check (
        .clk(clk), .rst_b(rst_b), .cs_b(lnk.cs_b), .sck(lnk.sck), .miso_oe(lnk.miso_oe),
        .busy(busy), .array_start(array_start), .array_erase(array_erase),
        .erase_program_error_flag(err));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Collects read bytes and records each self-timed operation
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            rx_q.push_back(rd_data);
        end
        if (array_start === 1'b1) begin
            n_start++;
            s_erase = array_erase;
            s_buf = array_buf;
            s_page = array_page;
        end
        if (busy === 1'b1) begin
            run++;
        end else if (run != 0) begin
            last_len = run;
            run = 0;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task tick;
        @(posedge clk);
        #2;
    endtask

    task cmd(input logic [7:0] op, input logic [23:0] a, input int n);
        int w;
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_addr = a;
        cmd_len = 10'(n);
        w = 0;
        while (cmd_ready !== 1'b1 && w < 100) begin
            tick;
            w++;
        end
        tick;
        cmd_valid = 1'b0;
        w = 0;
        while ((cmd_ready !== 1'b1 || busy !== 1'b0) && w < 30000) begin
            tick;
            w++;
        end
        tick;
        chk(w < 30000, 1);
    endtask

    task push_n(input logic [7:0] base, input int n);
        int w;
        for (int k = 0; k < n; k++) begin
            wr_valid = 1'b1;
            wr_data = base + 8'(k);
            w = 0;
            while (wr_ready !== 1'b1 && w < 100) begin
                tick;
                w++;
            end
            tick;
        end
        wr_valid = 1'b0;
    endtask

    // Fills the FIFO up front so a full load shows the refusal
    task wr(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] base);
        push_n(base, n);
        chk(wr_ready, n < 16);
        cmd(op, a, n);
        chk(wr_ready, 1);
    endtask

    task rd(input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] base);
        rx_q.delete();
        cmd(op, a, n);
        chk(rx_q.size(), n);
        foreach (rx_q[k]) begin
            chk(rx_q[k], base + 8'(k));
        end
    endtask

    task pg(input logic [7:0] op, input logic [23:0] a, input int n, input logic [11:0] page,
            input logic [1:0] eb, input int len, input logic e);
        int s0;
        s0 = n_start;
        cmd(op, a, n);
        chk(n_start, s0 + 1);
        chk({s_erase, s_buf}, eb);
        chk(s_page, page);
        chk(last_len, len);
        chk(err, e);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        bad_count++;
        close_out;
    end

    initial begin
        {rst_b, page_512, verify_fail, cmd_valid, wr_valid} = 5'h00;
        {cmd_opcode, wr_data, cmd_addr, cmd_len} = 50'h0;
        {bad_count, n_checks, n_start, run, last_len} = '0;
        repeat (2) @(posedge clk);
        #2 rst_b = 1'b1;
        wr(8'h84, 24'hfffe08, 16, 8'h30);
        rd(8'hd4, 24'hfffe08, 16, 8'h30);
        rd(8'hd1, 24'h000000, 8, 8'h38);
        rd(8'hd4, 24'h00020f, 2, 8'h37);
        wr(8'h87, 24'h000000, 4, 8'ha0);
        rd(8'hd3, 24'h000000, 4, 8'ha0);
        rd(8'hd6, 24'h000001, 3, 8'ha1);
        pg(8'h83, 24'heaf3ff, 0, 12'habc, 2'b10, EPC, 1'b0);
        pg(8'h86, 24'h155400, 0, 12'h555, 2'b11, EPC, 1'b0);
        verify_fail = 1'b1;
        pg(8'h89, 24'h155400, 0, 12'h555, 2'b01, PC, 1'b1);
        verify_fail = 1'b0;
        push_n(8'he0, 2);
        pg(8'h82, 24'h048c05, 2, 12'h123, 2'b10, EPC, 1'b0);
        rd(8'hd1, 24'h000005, 2, 8'he0);
        page_512 = 1'b1;
        wr(8'h84, 24'hfffffe, 4, 8'hc0);
        rd(8'hd4, 24'hfffffe, 4, 8'hc0);
        pg(8'h83, 24'hfffe00, 0, 12'hfff, 2'b10, EPC, 1'b0);
        pg(8'h88, 24'hffffff, 0, 12'hfff, 2'b00, PC, 1'b0);
        push_n(8'hf0, 2);
        pg(8'h85, 24'h100003, 2, 12'h800, 2'b11, EPC, 1'b0);
        rd(8'hd3, 24'h000003, 2, 8'hf0);
        close_out;
    end
endmodule

`default_nettype wire
